// ### hdl/dmx_pkg.sv
/*
   Shared constants and types of the data-move instruction executor.
   Assumes a 16-bit instruction word, a 12-bit data space and an 8-bit data path.
*/
package dmx_pkg;

   // Widths of the instruction word, the data address and the data byte.
   localparam int unsigned INSTR_W = 16;
   localparam int unsigned ADDR_W = 12;
   localparam int unsigned DATA_W = 8;

   // Field positions inside an instruction word.
   localparam int unsigned NIB_HI = 15;
   localparam int unsigned NIB_LO = 12;
   localparam int unsigned OP8_HI = 15;
   localparam int unsigned OP8_LO = 8;

   // Opcode nibbles of the two words of the file-to-file move.
   localparam logic [3:0] MOVE_SRC_NIB = 4'hC;
   localparam logic [3:0] MOVE_DST_NIB = 4'hF;

   // Opcode bytes of the two literal loads.
   localparam logic [7:0] BANK_LIT_OP = 8'h01;
   localparam logic [7:0] WORK_LIT_OP = 8'h0E;

   // The bank select register keeps only its low nibble.
   localparam logic [7:0] BANK_KEEP_MASK = 8'h0F;

   // Reset values of the core registers.
   localparam logic [7:0] WORK_RESET = 8'h00;
   localparam logic [7:0] BANK_RESET = 8'h00;

   // Default places of the core registers in the data space.
   localparam logic [11:0] WORK_ADDR_DEF = 12'hF00;
   localparam logic [11:0] BANK_ADDR_DEF = 12'hF01;

   // Quarter phases of one instruction cycle.
   typedef enum logic [1:0] {
      PH_Q1,
      PH_Q2,
      PH_Q3,
      PH_Q4
   } dmx_phase_e;

   // Instruction held by the executor during the current cycle.
   typedef enum logic [2:0] {
      OP_NONE,
      OP_MOVE_RD,
      OP_MOVE_WR,
      OP_BANK_LIT,
      OP_WORK_LIT
   } dmx_op_e;

   // Word from program memory.
   typedef struct packed {
      logic valid;
      logic [15:0] word;
   } dmx_fetch_s;

   // Request toward the data memory and special function register space.
   typedef struct packed {
      logic rd_en;
      logic wr_en;
      logic [11:0] addr;
      logic [7:0] wdata;
   } dmx_dmem_s;

endpackage

// ### hdl/dmx_core.sv
/*
   Execution core of the file-to-file move and the two literal loads.
   Assumes program memory presents a word in quarter phase one and that the
   data space answers a read in the same clock cycle, all on sys_clk.
*/
`timescale 1ns/1ns

// How it works
// - The move copies the source byte to the destination, touching no flag.
// - The move is two words: nibble 1100 with source, 1111 with destination.
// - Both 12-bit addresses reach the whole data space, ignoring the bank register.
// - The working register may be the source or the destination of the move.
// - Two cycles: read source in phase two, no second read, write in phase four.
// - Opcode 0000 0001 plus literal loads the bank register in one cycle.
// - The upper four bits of the bank register always read as zero.
// - Opcode 0000 1110 plus literal loads the working register in one cycle.
module dmx_core #(
   parameter logic [11:0] WORK_ADDR = dmx_pkg::WORK_ADDR_DEF,
   parameter logic [11:0] BANK_ADDR = dmx_pkg::BANK_ADDR_DEF
) (
   // Clock and reset.
   input wire logic sys_clk,
   input wire logic reset,
   // Program memory side.
   input dmx_pkg::dmx_fetch_s fetch,
   output logic fetch_take,
   // Data space side.
   output dmx_pkg::dmx_dmem_s dmem,
   input wire logic [7:0] dmem_rdata,
   // Core registers seen by the rest of the core.
   output logic [7:0] working_reg,
   output logic [7:0] bank_select_reg,
   output dmx_pkg::dmx_phase_e phase,
   output dmx_pkg::dmx_op_e cur_op
);
   import dmx_pkg::*;

   dmx_phase_e phase_r;
   dmx_op_e op_r;
   logic [11:0] src_addr_r;
   logic [11:0] dst_addr_r;
   logic [7:0] lit_r;
   logic [7:0] data_r;
   logic [7:0] work_r;
   logic [7:0] bank_r;
   logic [3:0] nib;
   logic [7:0] op8;
   logic rd_slot;
   logic wr_slot;
   logic src_internal;
   logic dst_internal;

   // Decode fields of the word on the fetch port.
   assign nib = fetch.word[NIB_HI:NIB_LO];
   assign op8 = fetch.word[OP8_HI:OP8_LO];

   // Quarter phases advance every clock; an instruction cycle is four clocks.
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         phase_r <= PH_Q1;
      end else begin
         unique case (phase_r)
            PH_Q1: phase_r <= PH_Q2;
            PH_Q2: phase_r <= PH_Q3;
            PH_Q3: phase_r <= PH_Q4;
            PH_Q4: phase_r <= PH_Q1;
         endcase
      end
   end

   // Decode at the end of phase one; a move in progress takes the next word
   // as its destination word, so a stray second word never starts anything.
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         op_r <= OP_NONE;
      end else if (phase_r == PH_Q1) begin
         if (op_r == OP_MOVE_RD) begin
            if (fetch.valid && nib == MOVE_DST_NIB) begin
               op_r <= OP_MOVE_WR;
            end else begin
               op_r <= OP_NONE;
            end
         end else if (!fetch.valid) begin
            op_r <= OP_NONE;
         end else if (nib == MOVE_SRC_NIB) begin
            op_r <= OP_MOVE_RD;
         end else if (op8 == BANK_LIT_OP) begin
            op_r <= OP_BANK_LIT;
         end else if (op8 == WORK_LIT_OP) begin
            op_r <= OP_WORK_LIT;
         end else begin
            op_r <= OP_NONE;
         end
      end
   end

   // Operand capture: full 12-bit addresses, so no bank register is involved.
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         src_addr_r <= 12'h000;
         dst_addr_r <= 12'h000;
         lit_r <= 8'h00;
      end else if (phase_r == PH_Q1 && fetch.valid) begin
         lit_r <= fetch.word[7:0];
         if (op_r == OP_MOVE_RD) begin
            dst_addr_r <= fetch.word[ADDR_W-1:0];
         end else if (nib == MOVE_SRC_NIB) begin
            src_addr_r <= fetch.word[ADDR_W-1:0];
         end
      end
   end

   // Bus slots: one read in phase two of the first cycle, one write in
   // phase four of the second; the second cycle issues no dummy read.
   assign rd_slot = (phase_r == PH_Q2) && (op_r == OP_MOVE_RD);
   assign wr_slot = (phase_r == PH_Q4) && (op_r == OP_MOVE_WR);
   assign src_internal = (src_addr_r == WORK_ADDR) || (src_addr_r == BANK_ADDR);
   assign dst_internal = (dst_addr_r == WORK_ADDR) || (dst_addr_r == BANK_ADDR);

   // The core registers live here, so moves to or from them stay off the bus.
   assign dmem.rd_en = rd_slot && !src_internal;
   assign dmem.wr_en = wr_slot && !dst_internal;
   assign dmem.addr = (op_r == OP_MOVE_WR) ? dst_addr_r : src_addr_r;
   assign dmem.wdata = data_r;
   assign fetch_take = (phase_r == PH_Q1);

   // Source byte is sampled at the end of phase two; the source is not written.
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         data_r <= 8'h00;
      end else if (rd_slot) begin
         if (src_addr_r == WORK_ADDR) begin
            data_r <= work_r;
         end else if (src_addr_r == BANK_ADDR) begin
            data_r <= bank_r;
         end else begin
            data_r <= dmem_rdata;
         end
      end
   end

   // Working register: literal load or move destination, both in phase four.
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         work_r <= WORK_RESET;
      end else if (phase_r == PH_Q4) begin
         if (op_r == OP_WORK_LIT) begin
            work_r <= lit_r;
         end else if (op_r == OP_MOVE_WR && dst_addr_r == WORK_ADDR) begin
            work_r <= data_r;
         end
      end
   end

   // Bank register: the mask keeps the high nibble at zero on every write path.
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         bank_r <= BANK_RESET;
      end else if (phase_r == PH_Q4) begin
         if (op_r == OP_BANK_LIT) begin
            bank_r <= lit_r & BANK_KEEP_MASK;
         end else if (op_r == OP_MOVE_WR && dst_addr_r == BANK_ADDR) begin
            bank_r <= data_r & BANK_KEEP_MASK;
         end
      end
   end

   // No flag register exists in this block, so none of these moves can alter one.
   assign working_reg = work_r;
   assign bank_select_reg = bank_r;
   assign phase = phase_r;
   assign cur_op = op_r;

   // Checks on the executor.
   a_read_phase_two: assert property (@(posedge sys_clk) disable iff (reset)
      dmem.rd_en |-> phase_r == PH_Q2 && op_r == OP_MOVE_RD)
      else $error("Data read outside phase two of a move.");

   a_write_after_read: assert property (@(posedge sys_clk) disable iff (reset)
      wr_slot |-> $past(rd_slot, 6))
      else $error("Move write not six clocks after its read slot.");

   a_no_dummy_read: assert property (@(posedge sys_clk) disable iff (reset)
      op_r == OP_MOVE_WR |-> !dmem.rd_en)
      else $error("Read issued in the second cycle of a move.");

   a_source_copied: assert property (@(posedge sys_clk) disable iff (reset)
      dmem.rd_en |=> data_r == $past(dmem_rdata) && !$past(dmem.wr_en))
      else $error("Source byte not captured from the data space.");

   a_dest_full_addr: assert property (@(posedge sys_clk) disable iff (reset)
      dmem.wr_en |-> dmem.addr == $past(fetch.word[11:0], 3))
      else $error("Write address differs from the destination word.");

   a_second_word: assert property (@(posedge sys_clk) disable iff (reset)
      phase_r == PH_Q1 && op_r == OP_MOVE_RD && !(fetch.valid && nib == MOVE_DST_NIB)
      |=> op_r == OP_NONE)
      else $error("Move went on without a destination word.");

   a_work_as_dest: assert property (@(posedge sys_clk) disable iff (reset)
      wr_slot && dst_addr_r == WORK_ADDR |-> !dmem.wr_en ##1 work_r == $past(data_r))
      else $error("Move into the working register went wrong.");

   a_bank_literal: assert property (@(posedge sys_clk) disable iff (reset)
      phase_r == PH_Q4 && op_r == OP_BANK_LIT |=> bank_r == {4'h0, $past(lit_r[3:0])})
      else $error("Bank literal not loaded.");

   a_bank_high_zero: assert property (@(posedge sys_clk) disable iff (reset)
      bank_r[7:4] == 4'h0)
      else $error("Bank register high nibble not zero.");

   a_work_literal: assert property (@(posedge sys_clk) disable iff (reset)
      phase_r == PH_Q4 && op_r == OP_WORK_LIT |=> work_r == $past(lit_r))
      else $error("Working literal not loaded.");

   c_move_bus: cover property (@(posedge sys_clk) disable iff (reset)
      dmem.rd_en ##6 dmem.wr_en);
   c_move_work: cover property (@(posedge sys_clk) disable iff (reset)
      wr_slot && dst_addr_r == WORK_ADDR);
   c_bank_load: cover property (@(posedge sys_clk) disable iff (reset)
      phase_r == PH_Q4 && op_r == OP_BANK_LIT && lit_r[7:4] != 4'h0);
   c_work_load: cover property (@(posedge sys_clk) disable iff (reset)
      phase_r == PH_Q4 && op_r == OP_WORK_LIT);

endmodule // dmx_core

// ### dv/dmx_dmem_model.sv
/*
   Behavioural data space behind the executor's bus.
   Assumes a request struct from the executor and a bench that preloads mem directly.
*/
`timescale 1ns/1ns
module dmx_dmem_model (
   // Clock.
   input wire logic sys_clk,
   // Bus from the executor.
   input dmx_pkg::dmx_dmem_s dmem,
   output logic [7:0] dmem_rdata
);
   import dmx_pkg::*;
   logic [7:0] mem [0:4095];
   logic [7:0] junk_r = 8'hA5;
   // Read data is valid only in the strobe clock; a toggling pattern exposes late sampling.
   assign dmem_rdata = dmem.rd_en ? mem[dmem.addr] : junk_r;
   // Writes land at the edge that ends the strobe clock.
   always @(posedge sys_clk) begin
      junk_r <= ~junk_r;
      if (dmem.wr_en) begin
         mem[dmem.addr] <= dmem.wdata;
      end
   end
endmodule // dmx_dmem_model

// ### dv/data_move_instruction_exec_test.sv
/*
   Self-checking bench of the data-move executor with a data space model.
   Assumes words are presented one instruction cycle apart, starting just after reset.
*/
`timescale 1ns/1ns
module data_move_instruction_exec_test;
   import dmx_pkg::*;
   logic sys_clk;
   logic reset;
   dmx_fetch_s fetch;
   logic fetch_take;
   dmx_dmem_s dmem;
   logic [7:0] dmem_rdata;
   logic [7:0] working_reg;
   logic [7:0] bank_select_reg;
   dmx_phase_e phase;
   dmx_op_e cur_op;
   int error_cnt = 0;
   int num_checks = 0;
   int seed;
   int cyc = 0;
   int rd_cnt = 0;
   int wr_cnt = 0;
   int w0;
   logic [11:0] s;
   logic [11:0] d;
   logic [7:0] v;
   logic [7:0] bk;

   dmx_core dut (.sys_clk(sys_clk), .reset(reset), .fetch(fetch), .fetch_take(fetch_take),
      .dmem(dmem), .dmem_rdata(dmem_rdata), .working_reg(working_reg),
      .bank_select_reg(bank_select_reg), .phase(phase), .cur_op(cur_op));
   dmx_dmem_model u_mem (.sys_clk(sys_clk), .dmem(dmem), .dmem_rdata(dmem_rdata));

   // Free running clock at 25 MHz.
   initial begin
      sys_clk = 1'b0;
      forever #20 sys_clk = ~sys_clk;
   end

   function automatic logic [7:0] exp_bank(input logic [7:0] k);
      return k & 8'h0F;
   endfunction

   task automatic check(input string what, input logic [11:0] seen, input logic [11:0] exp);
      num_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("unexpected %s: expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   // One word per instruction cycle; the call returns just after the cycle's last edge.
   task automatic issue(input logic [15:0] w);
      check("fetch take", fetch_take, 1'b1);
      fetch <= '{valid: 1'b1, word: w};
      repeat (4) @(posedge sys_clk);
      #1;
   endtask

   task automatic move(input logic [11:0] src, input logic [11:0] dst, input int rds,
      input int wrs);
      int r0;
      int q0;
      r0 = rd_cnt;
      q0 = wr_cnt;
      issue({MOVE_SRC_NIB, src});
      issue({MOVE_DST_NIB, dst});
      check("read strobes", rd_cnt - r0, rds);
      check("write strobes", wr_cnt - q0, wrs);
   endtask

   // Hang guard; the ceiling is far above the few hundred clocks the run needs.
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc > 20000) begin
         error_cnt++;
         report_and_stop();
      end
   end

   // Strobe watcher; it reads the values that stood during the clock just ended.
   always @(posedge sys_clk) begin
      if (!reset && dmem.rd_en === 1'b1) begin
         rd_cnt++;
         check("read phase", phase, PH_Q2);
      end
      if (!reset && dmem.wr_en === 1'b1) begin
         wr_cnt++;
         check("write phase", phase, PH_Q4);
      end
   end

   // Main sequence.
   initial begin
      seed = 15333;
      reset = 1'b1;
      fetch = '0;
      for (int i = 0; i < 4096; i++) u_mem.mem[i] = i[7:0] ^ 8'h5A;
      repeat (20) @(posedge sys_clk);
      #1 reset = 1'b0;
      check("working reset", working_reg, WORK_RESET);
      check("bank reset", bank_select_reg, BANK_RESET);
      check("op reset", cur_op, OP_NONE);
      for (int i = 0; i < 6; i++) begin
         v = (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : 8'($random(seed));
         issue({WORK_LIT_OP, v});
         check("working", working_reg, v);
         issue({BANK_LIT_OP, ~v});
         check("bank", bank_select_reg, exp_bank(~v));
         bk = exp_bank(~v);
         check("working kept", working_reg, v);
      end
      $display("test literal loads done");
      // Destinations stay below the core area where the working and bank registers sit.
      for (int i = 0; i < 22; i++) begin
         s = 12'($random(seed));
         d = 12'($random(seed));
         if (s >= 12'hF00) s = s - 12'h100;
         if (d >= 12'hF00) d = d - 12'h100;
         if (i == 0) s = 12'hFFF;
         if (i == 0) d = 12'h000;
         if (i == 1) s = 12'h000;
         if (i == 1) d = 12'hEFF;
         v = 8'($random(seed));
         u_mem.mem[s] = v;
         move(s, d, 1, 1);
         check("dest byte", u_mem.mem[d], v);
         check("source byte", u_mem.mem[s], v);
         check("bank untouched", bank_select_reg, bk);
      end
      $display("test file moves done");
      issue({WORK_LIT_OP, 8'hC3});
      move(WORK_ADDR_DEF, 12'h123, 0, 1);
      check("from working", u_mem.mem[12'h123], 8'hC3);
      u_mem.mem[12'h045] = 8'h96;
      move(12'h045, WORK_ADDR_DEF, 1, 0);
      check("to working", working_reg, 8'h96);
      // The bank register as move operand: the high nibble must be dropped on the way in.
      u_mem.mem[12'h0AB] = 8'hE7;
      move(12'h0AB, BANK_ADDR_DEF, 1, 0);
      check("bank from move", bank_select_reg, exp_bank(8'hE7));
      move(BANK_ADDR_DEF, 12'h200, 0, 1);
      check("from bank", u_mem.mem[12'h200], exp_bank(8'hE7));
      $display("test working operand done");
      w0 = wr_cnt;
      issue({MOVE_SRC_NIB, 12'h0AA});
      issue({WORK_LIT_OP, 8'h3C});
      issue({MOVE_DST_NIB, 12'h300});
      issue(16'h0000);
      check("aborted writes", wr_cnt - w0, 0);
      check("aborted literal", working_reg, 8'h96);
      $display("test broken pairs done");
      report_and_stop();
   end
endmodule // data_move_instruction_exec_test
